// ---- checksum_and_bit_ops_unit.sv ----
// instruction unit: check codes over word runs plus word bit operations
// assumes a same-clock word memory and bit-element store outside
//
// Summary of operation
// (R1) CCITT code uses x^16+x^12+x^5+1 over 16 bits.
// (R2) CRC16 code uses x^16+x^15+x^2+1 over 16 bits.
// (R3) check walks count words from start element, result to destination.
// (R4) destination content seeds the check; program clears it first.
// (R5) for MODBUS, program presets all ones and swaps result bytes.
// (R6) only the low byte of each data word enters the check.
// (R7) CCITT and CRC16 results fill the whole destination word.
// (R8) LRC result sits in the destination low byte.
// (R9) negative count rejects the check with an operand error.
// (R10) zone reset clears a run of bit elements from destination.
// (R11) zone reset also clears counter and timer accumulated values.
// (R12) zone set drives a run of bit elements to one.
// (R13) decode writes a one-hot word indexed by source 0 to 15.
// (R14) decode index out of range leaves destination, flags operand error.
// (R15) encode writes the lowest index of a one bit in source.
// (R16) word pop count stores the number of ones in 16 bits.
// (R17) dword pop count stores the number of ones in 32 bits.
// (R18) LRC is seed plus negated 8-bit sum of the data bytes.
// (R19) CRC16 shifts bytes lsb first, CCITT shifts msb first.
// (R20) encode of a zero source leaves destination, flags operand error.
`timescale 1ns/1ps
module checksum_and_bit_ops_unit (
  input  logic               clk_sys,
  input  logic               rst_n,
  input  logic               cmd_valid,
  output logic               cmd_ready,
  input  chk_bit_pkg::op_t   cmd_op,
  input  logic [15:0]        cmd_start_element,
  input  logic signed [15:0] cmd_word_count,
  input  logic [15:0]        cmd_dst,
  input  logic [31:0]        cmd_operand,
  output logic               op_done,
  output logic               op_error,
  output logic               mem_rd_req,
  output logic [15:0]        mem_rd_addr,
  input  logic               mem_rd_valid,
  input  logic [15:0]        mem_rd_data,
  output logic               mem_wr_req,
  output logic [15:0]        mem_wr_addr,
  output logic [15:0]        mem_wr_data,
  output logic               bit_wr_req,
  output logic [15:0]        bit_wr_addr,
  output logic               bit_wr_value,
  output logic               bit_acc_clear
);
  import chk_bit_pkg::*;

  typedef enum {
    st_idle,
    st_seed_rd,
    st_seed_wait,
    st_data_rd,
    st_data_wait,
    st_result_wr,
    st_bitop,
    st_zone,
    st_finish
  } state_t;

  state_t      state_q;
  state_t      state_d;
  op_t         op_q;
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  logic [15:0] rem_q;
  logic [15:0] rem_d;
  logic [15:0] dst_q;
  logic [31:0] opnd_q;
  logic        err_q;
  logic        err_d;

  logic        mem_rd_req_q;
  logic [15:0] mem_rd_addr_q;
  logic        mem_wr_req_q;
  logic [15:0] mem_wr_addr_q;
  logic [15:0] mem_wr_data_q;
  logic        bit_wr_req_q;
  logic [15:0] bit_wr_addr_q;
  logic        bit_wr_value_q;
  logic        bit_acc_clear_q;
  logic        op_done_q;
  logic        op_error_q;

  logic [15:0] decode_word;
  logic        decode_err;
  logic [3:0]  encode_idx;
  logic        encode_err;
  logic [5:0]  pop_word;
  logic [5:0]  pop_dword;

  chk_if ch ();

  check_engine u_engine (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ch      (ch.eng)
  );

  bit_ops_unit u_bitops (
    .operand     (opnd_q),
    .decode_word (decode_word),
    .decode_err  (decode_err),
    .encode_idx  (encode_idx),
    .encode_err  (encode_err),
    .pop_word    (pop_word),
    .pop_dword   (pop_dword)
  );

  // command decode
  wire cmd_is_check = (cmd_op == op_ccitt) || (cmd_op == op_crc16) ||
                      (cmd_op == op_lrc);
  wire cmd_is_zone  = (cmd_op == op_zone_bit_reset) ||
                      (cmd_op == op_zone_bit_set);
  wire cmd_is_bitop = (cmd_op == op_one_hot_decode) ||
                      (cmd_op == op_lowest_bit_encode) ||
                      (cmd_op == op_word_pop_count) ||
                      (cmd_op == op_dword_pop_count);
  wire cmd_count_neg = cmd_word_count < 0;
  wire cmd_take     = cmd_valid && (state_q == st_idle);

  wire in_seed_rd   = state_q == st_seed_rd;
  wire in_data_rd   = state_q == st_data_rd;
  wire in_seed_wait = state_q == st_seed_wait;
  wire in_data_wait = state_q == st_data_wait;
  wire in_result_wr = state_q == st_result_wr;
  wire in_bitop     = state_q == st_bitop;
  wire in_zone      = state_q == st_zone;

  // bit operation select
  wire is_decode = op_q == op_one_hot_decode;
  wire is_encode = op_q == op_lowest_bit_encode;
  wire is_pop16  = op_q == op_word_pop_count;
  wire bitop_err = (is_decode && decode_err) ||             // R14
                   (is_encode && encode_err);               // R20
  wire [15:0] bitop_word =
    is_decode ? decode_word :                               // R13
    is_encode ? {12'h000, encode_idx} :                     // R15
    is_pop16  ? {10'h000, pop_word} :                       // R16
                {10'h000, pop_dword};                       // R17

  // engine feed
  assign ch.mode       = (op_q == op_ccitt) ? mode_ccitt :
                         (op_q == op_crc16) ? mode_crc16 : mode_lrc;
  assign ch.seed_load  = in_seed_wait && mem_rd_valid;      // R4
  assign ch.seed       = mem_rd_data;
  assign ch.byte_valid = in_data_wait && mem_rd_valid;
  assign ch.data_byte  = mem_rd_data[7:0];                  // R6

  // memory and bit-store request terms
  wire        rd_go   = in_seed_rd || in_data_rd;
  wire [15:0] rd_addr = in_seed_rd ? dst_q : ptr_q;
  // failed decode or encode never writes, so destination stays intact
  wire        wr_go   = in_result_wr || (in_bitop && !bitop_err);
  wire [15:0] wr_data = in_result_wr ? ch.result : bitop_word; // R3
  wire        zone_set = op_q == op_zone_bit_set;

  always_comb
  begin
    state_d = state_q;
    ptr_d   = ptr_q;
    rem_d   = rem_q;
    err_d   = err_q;
    unique case (state_q)
      st_idle:
      begin
        if (cmd_valid)
        begin
          err_d = 1'b0;
          ptr_d = cmd_is_zone ? cmd_dst : cmd_start_element;
          rem_d = 16'(unsigned'(cmd_word_count));
          if (cmd_is_check && cmd_count_neg)
          begin
            err_d   = 1'b1;                                 // R9
            state_d = st_finish;
          end
          else if (cmd_is_check)
            state_d = st_seed_rd;                           // R3
          else if (cmd_is_zone)
            state_d = (cmd_count_neg || cmd_word_count == 0) ?
                      st_finish : st_zone;
          else if (cmd_is_bitop)
            state_d = st_bitop;
          else
          begin
            // unknown code: refuse rather than write a guessed word
            err_d   = 1'b1;
            state_d = st_finish;
          end
        end
      end
      st_seed_rd:
        state_d = st_seed_wait;
      st_seed_wait:
      begin
        if (mem_rd_valid)
          state_d = (rem_q == WORD_ZERO) ? st_result_wr : st_data_rd;
      end
      st_data_rd:
        state_d = st_data_wait;
      st_data_wait:
      begin
        if (mem_rd_valid)
        begin
          ptr_d   = ptr_q + ADDR_ONE;                       // R3
          rem_d   = rem_q - ADDR_ONE;
          state_d = (rem_q == ADDR_ONE) ? st_result_wr : st_data_rd;
        end
      end
      st_result_wr:
        state_d = st_finish;
      st_bitop:
      begin
        err_d   = bitop_err;
        state_d = st_finish;
      end
      st_zone:
      begin
        ptr_d   = ptr_q + ADDR_ONE;                         // R10 R12
        rem_d   = rem_q - ADDR_ONE;
        if (rem_q == ADDR_ONE)
          state_d = st_finish;
      end
      st_finish:
        state_d = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= st_idle;
      ptr_q   <= WORD_ZERO;
      rem_q   <= WORD_ZERO;
      err_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      rem_q   <= rem_d;
      err_q   <= err_d;
    end
  end

  // command fields held for the whole operation
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q   <= op_ccitt;
      dst_q  <= WORD_ZERO;
      opnd_q <= 32'h0000_0000;
    end
    else if (cmd_take)
    begin
      op_q   <= cmd_op;
      dst_q  <= cmd_dst;
      opnd_q <= cmd_operand;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rd_req_q  <= 1'b0;
      mem_rd_addr_q <= WORD_ZERO;
    end
    else
    begin
      mem_rd_req_q  <= rd_go;
      if (rd_go)
        mem_rd_addr_q <= rd_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_req_q  <= 1'b0;
      mem_wr_addr_q <= WORD_ZERO;
      mem_wr_data_q <= WORD_ZERO;
    end
    else
    begin
      mem_wr_req_q <= wr_go;
      if (wr_go)
      begin
        mem_wr_addr_q <= dst_q;
        mem_wr_data_q <= wr_data;                           // R7 R8
      end
    end
  end

  // one element per cycle; the store clears c/t values on bit_acc_clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_wr_req_q    <= 1'b0;
      bit_wr_addr_q   <= WORD_ZERO;
      bit_wr_value_q  <= 1'b0;
      bit_acc_clear_q <= 1'b0;
    end
    else
    begin
      bit_wr_req_q    <= in_zone;
      bit_acc_clear_q <= in_zone && !zone_set;              // R11
      if (in_zone)
      begin
        bit_wr_addr_q  <= ptr_q;
        bit_wr_value_q <= zone_set;                         // R10 R12
      end
    end
  end

  // status from flops; same timing as the state decode, no glitches
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_done_q  <= 1'b0;
      op_error_q <= 1'b0;
    end
    else
    begin
      op_done_q  <= state_d == st_finish;
      op_error_q <= (state_d == st_finish) && err_d;        // R9 R14 R20
    end
  end

  assign cmd_ready     = state_q == st_idle;
  assign op_done       = op_done_q;
  assign op_error      = op_error_q;
  assign mem_rd_req    = mem_rd_req_q;
  assign mem_rd_addr   = mem_rd_addr_q;
  assign mem_wr_req    = mem_wr_req_q;
  assign mem_wr_addr   = mem_wr_addr_q;
  assign mem_wr_data   = mem_wr_data_q;
  assign bit_wr_req    = bit_wr_req_q;
  assign bit_wr_addr   = bit_wr_addr_q;
  assign bit_wr_value  = bit_wr_value_q;
  assign bit_acc_clear = bit_acc_clear_q;
endmodule // checksum_and_bit_ops_unit

// ---- chk_bit_pkg.sv ----
// constants and types shared by the check-code and bit-operation unit
// assumes one 100 MHz clock and a word memory outside the unit
package chk_bit_pkg;

  localparam int          WORD_W          = 16;
  localparam int          DWORD_W         = 32;
  localparam int          BYTE_W          = 8;
  localparam int          ADDR_W          = 16;
  localparam int          IDX_W           = 4;
  localparam int          POP_W           = 6;

  // x^16 + x^12 + x^5 + 1, shifted msb first
  localparam logic [15:0] CCITT_POLY      = 16'h1021;
  // x^16 + x^15 + x^2 + 1, bit reversed for lsb-first shifting
  localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;

  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [15:0] ADDR_ONE        = 16'h0001;
  localparam logic [15:0] DECODE_MAX      = 16'h000F;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  typedef enum logic [3:0] {
    op_ccitt,
    op_crc16,
    op_lrc,
    op_zone_bit_reset,
    op_zone_bit_set,
    op_one_hot_decode,
    op_lowest_bit_encode,
    op_word_pop_count,
    op_dword_pop_count
  } op_t;

  typedef enum logic [1:0] {
    mode_ccitt,
    mode_crc16,
    mode_lrc
  } chk_mode_t;

endpackage

// ---- chk_if.sv ----
// link between the sequencer and the check-code engine
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface chk_if;
  import chk_bit_pkg::*;

  logic        seed_load;
  logic [15:0] seed;
  chk_mode_t   mode;
  logic        byte_valid;
  logic [7:0]  data_byte;
  logic [15:0] result;

  modport ctrl (
    output seed_load,
    output seed,
    output mode,
    output byte_valid,
    output data_byte,
    input  result
  );

  modport eng (
    input  seed_load,
    input  seed,
    input  mode,
    input  byte_valid,
    input  data_byte,
    output result
  );
endinterface // chk_if

// ---- check_engine.sv ----
// byte-serial accumulator for ccitt, crc16 and lrc codes
// assumes seed_load comes before the first byte of each run
`timescale 1ns/1ps
module check_engine (
  input  logic clk_sys,
  input  logic rst_n,
  chk_if.eng   ch
);
  import chk_bit_pkg::*;

  logic [15:0] acc_q;
  logic [15:0] acc_d;

  // whole byte folded in one cycle; eight shifts unrolled by the loop
  function automatic logic [15:0] ccitt_step(input logic [15:0] c,
                                             input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {b, BYTE_ZERO};
    for (int i = 0; i < BYTE_W; i++)
      r = r[15] ? ({r[14:0], 1'b0} ^ CCITT_POLY) : {r[14:0], 1'b0};
    return r;
  endfunction

  function automatic logic [15:0] crc16_step(input logic [15:0] c,
                                             input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {BYTE_ZERO, b};
    for (int i = 0; i < BYTE_W; i++)
      r = r[0] ? ({1'b0, r[15:1]} ^ CRC16_POLY_REFL) : {1'b0, r[15:1]};
    return r;
  endfunction

  always_comb
  begin
    unique case (ch.mode)
      mode_ccitt: acc_d = ccitt_step(acc_q, ch.data_byte);   // R1 R19
      mode_crc16: acc_d = crc16_step(acc_q, ch.data_byte);   // R2 R19
      // seed minus running sum equals seed plus negated sum
      default:    acc_d = {acc_q[15:8], acc_q[7:0] - ch.data_byte}; // R18
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      acc_q <= WORD_ZERO;
    else if (ch.seed_load)
      acc_q <= ch.seed;                                      // R4
    else if (ch.byte_valid)
      acc_q <= acc_d;
  end

  assign ch.result = (ch.mode == mode_lrc) ? {BYTE_ZERO, acc_q[7:0]} // R8
                                           : acc_q;          // R7
endmodule // check_engine

// ---- bit_ops_unit.sv ----
// combinational decode, lowest-bit encode and population counts
// assumes the operand is held stable by the sequencer
`timescale 1ns/1ps
module bit_ops_unit (
  input  logic [31:0] operand,
  output logic [15:0] decode_word,
  output logic        decode_err,
  output logic [3:0]  encode_idx,
  output logic        encode_err,
  output logic [5:0]  pop_word,
  output logic [5:0]  pop_dword
);
  import chk_bit_pkg::*;

  logic [16:0] seen;
  logic [15:0] first;
  logic [15:0][3:0] idx_term;

  assign seen[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < WORD_W; g++)
    begin : g_bit
      assign decode_word[g] = (operand[15:0] == 16'(g));    // R13
      assign seen[g+1]      = seen[g] | operand[g];
      assign first[g]       = operand[g] & ~seen[g];
      assign idx_term[g]    = first[g] ? 4'(g) : 4'h0;
    end
  endgenerate

  assign decode_err = operand[15:0] > DECODE_MAX;           // R14
  assign encode_err = ~seen[WORD_W];                        // R20

  always_comb
  begin
    encode_idx = 4'h0;
    for (int i = 0; i < WORD_W; i++)
      encode_idx = encode_idx | idx_term[i];                // R15
  end

  always_comb
  begin
    pop_word  = 6'h00;
    pop_dword = 6'h00;
    for (int i = 0; i < DWORD_W; i++)
    begin
      if (i < WORD_W)
        pop_word = pop_word + 6'(operand[i]);               // R16
      pop_dword = pop_dword + 6'(operand[i]);               // R17
    end
  end
endmodule // bit_ops_unit

// ---- chk_bit_checker.sv ----
// assertion checker for the check-code and bit-operation unit
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module chk_bit_checker
  import chk_bit_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire chk_bit_pkg::op_t   cmd_op,
  input wire logic signed [15:0] cmd_word_count,
  input wire logic [15:0]        cmd_dst,
  input wire logic [31:0]        cmd_operand,
  input wire logic               op_done,
  input wire logic               op_error,
  input wire logic               mem_rd_req,
  input wire logic               mem_wr_req,
  input wire logic [15:0]        mem_wr_addr,
  input wire logic [15:0]        mem_wr_data,
  input wire logic               bit_wr_req,
  input wire logic               bit_wr_value,
  input wire logic               bit_acc_clear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire take    = cmd_valid && cmd_ready;
  wire is_chk  = cmd_op inside {op_ccitt, op_crc16, op_lrc};
  wire is_zone = cmd_op inside {op_zone_bit_reset, op_zone_bit_set};
  wire is_dec  = take && cmd_op == op_one_hot_decode;
  wire is_word = cmd_op inside {op_one_hot_decode, op_lowest_bit_encode,
                                op_word_pop_count, op_dword_pop_count};

  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("done held longer than one cycle");
  a_error_done: assert property (op_error |-> op_done)
    else $error("error flag without done");
  a_busy_block: assert property (take |=> !cmd_ready)
    else $error("ready stayed high after a command was taken");
  a_neg_count: assert property (take && is_chk && cmd_word_count[15]
    |=> op_done && op_error && !mem_rd_req && !mem_wr_req)
    else $error("negative count not refused");
  a_word_latency: assert property (take && is_word |-> ##2 op_done)
    else $error("bit operation not done two cycles after take");
  a_decode_word: assert property (is_dec && cmd_operand[15:0] <= DECODE_MAX
    |-> ##2 mem_wr_req && mem_wr_addr == $past(cmd_dst, 2)
    && mem_wr_data == (16'h0001 << $past(cmd_operand[3:0], 2)))
    else $error("decode wrote a wrong word");
  a_decode_range: assert property (is_dec && cmd_operand[15:0] > DECODE_MAX
    |-> ##2 op_error && !mem_wr_req)
    else $error("decode out of range not refused");
  a_encode_zero: assert property (take && cmd_op == op_lowest_bit_encode
    && cmd_operand[15:0] == 16'h0000 |-> ##2 op_error && !mem_wr_req)
    else $error("encode of zero not refused");
  a_acc_clear: assert property (bit_acc_clear
    |-> bit_wr_req && !bit_wr_value)
    else $error("value clear outside a zone reset write");
  a_zone_empty: assert property (take && is_zone
    && cmd_word_count < 16'sh0001 |=> !bit_wr_req [*3])
    else $error("empty zone wrote an element");

  c_check: cover property (take && is_chk && !cmd_word_count[15]);
  c_error: cover property (op_error);
  c_clear: cover property (bit_acc_clear);
endmodule // chk_bit_checker

bind checksum_and_bit_ops_unit chk_bit_checker i_chk_bit_checker (
  .clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_word_count,
  .cmd_dst, .cmd_operand, .op_done, .op_error, .mem_rd_req, .mem_wr_req,
  .mem_wr_addr, .mem_wr_data, .bit_wr_req, .bit_wr_value, .bit_acc_clear
);

// ---- testbench.sv ----
// self-checking bench for the check-code and bit-operation unit
// assumes a one-cycle word memory and bit store modelled here
`timescale 1ns/1ps
module testbench;
  import chk_bit_pkg::*;
  typedef struct packed {
    op_t         op;
    logic [31:0] src;
    logic [15:0] exp;
    logic        err;
  } row_t;

  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               cmd_valid = 1'b0;
  op_t                cmd_op = op_ccitt;
  logic [15:0]        cmd_start_element = 16'h0000;
  logic signed [15:0] cmd_word_count = 16'sh0000;
  logic [15:0]        cmd_dst = 16'h0000;
  logic [31:0]        cmd_operand = 32'h0000_0000;
  logic               mem_rd_valid = 1'b0;
  logic [15:0]        mem_rd_data = 16'h0000;
  logic               cmd_ready, op_done, op_error, mem_rd_req;
  logic               mem_wr_req, bit_wr_req, bit_wr_value, bit_acc_clear;
  logic [15:0]        mem_rd_addr, mem_wr_addr, mem_wr_data, bit_wr_addr;
  logic [15:0]        mem [0:63];
  logic [63:0]        bits = 64'h0;
  int                 n_acc = 0, cyc = 0, n_mismatch = 0, total_checks = 0;
  logic               err;
  int                 b0;
  op_t                modes [3] = '{op_ccitt, op_crc16, op_lrc};
  logic [15:0]        seeds [3] = '{16'h1D0F, 16'hFFFF, 16'h1234};
  logic signed [15:0] cnts [4] = '{16'sh0008, 16'sh0001, 16'sh0000,
                                   16'shFFFF};
  row_t rows [11] = '{
    '{op_one_hot_decode,    32'h0000_0002, 16'h0004, 1'b0},
    '{op_one_hot_decode,    32'hFFFF_000F, 16'h8000, 1'b0},
    '{op_one_hot_decode,    32'h0000_0010, 16'hBEEF, 1'b1},
    '{op_lowest_bit_encode, 32'h0000_8010, 16'h0004, 1'b0},
    '{op_lowest_bit_encode, 32'h0000_8000, 16'h000F, 1'b0},
    '{op_lowest_bit_encode, 32'hFFFF_0000, 16'hBEEF, 1'b1},
    '{op_word_pop_count,    32'hFFFF_F0F0, 16'h0008, 1'b0},
    '{op_word_pop_count,    32'h0000_FFFF, 16'h0010, 1'b0},
    '{op_dword_pop_count,   32'h000F_F0FF, 16'h0010, 1'b0},
    '{op_dword_pop_count,   32'hFFFF_FFFF, 16'h0020, 1'b0},
    '{op_t'(4'hF),          32'h0000_FFFF, 16'hBEEF, 1'b1}};

  checksum_and_bit_ops_unit i_checksum_and_bit_ops_unit (
    .clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_start_element,
    .cmd_word_count, .cmd_dst, .cmd_operand, .op_done, .op_error,
    .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .mem_wr_req,
    .mem_wr_addr, .mem_wr_data, .bit_wr_req, .bit_wr_addr, .bit_wr_value,
    .bit_acc_clear);

  always #5 clk_sys = ~clk_sys;

  // memory answers one cycle later; idle data toggles so stale reads show
  always @(posedge clk_sys)
  begin
    mem_rd_valid <= mem_rd_req;
    mem_rd_data  <= mem_rd_req ? mem[mem_rd_addr[5:0]] : ~mem_rd_data;
    if (mem_wr_req)
      mem[mem_wr_addr[5:0]] <= mem_wr_data;
    if (bit_wr_req)
      bits[bit_wr_addr[5:0]] <= bit_wr_value;
    if (bit_acc_clear)
      n_acc <= n_acc + 1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_w(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_b(input string nm, input logic e, g);
    chk_w(nm, {15'h0, e}, {15'h0, g});
  endtask

  task automatic run(input op_t op, input logic signed [15:0] n,
                     input logic [15:0] dst, input logic [31:0] src);
    @(posedge clk_sys);
    cmd_op         <= op;
    cmd_word_count <= n;
    cmd_dst        <= dst;
    cmd_operand    <= src;
    cmd_valid      <= 1'b1;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do @(negedge clk_sys); while (op_done !== 1'b1);
    err = op_error;
    // one more edge so the final write has landed in the store
    @(negedge clk_sys);
  endtask

  function automatic logic [15:0] calc(input op_t op, input logic [15:0] sd,
                                       input int st, input int n);
    logic [15:0] c;
    logic [7:0]  s;
    logic [7:0]  b;
    c = sd;
    s = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      b = mem[st + i][7:0];
      s = s + b;
      if (op == op_ccitt)
      begin
        c = c ^ {b, 8'h00};
        for (int j = 0; j < 8; j++)
          c = c[15] ? (c << 1) ^ CCITT_POLY : c << 1;
      end
      else
      begin
        c = c ^ {8'h00, b};
        for (int j = 0; j < 8; j++)
          c = c[0] ? (c >> 1) ^ CRC16_POLY_REFL : c >> 1;
      end
    end
    return (op == op_lrc) ? {8'h00, sd[7:0] - s} : c;
  endfunction

  initial
  begin
    // upper bytes set so any leak into the codes shows
    for (int i = 0; i < 64; i++)
      mem[i] = {8'hC3, 8'(8'h37 * i + 8'h05)};
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk_b("ready after reset", 1'b1, cmd_ready);
    chk_b("done after reset", 1'b0, op_done);
    foreach (rows[r])
    begin
      mem[40] = 16'hBEEF;
      run(rows[r].op, 16'sh0000, 16'h0028, rows[r].src);
      chk_w("bit op word", rows[r].exp, mem[40]);
      chk_b("bit op error", rows[r].err, err);
    end
    foreach (modes[m])
      foreach (cnts[c])
      begin
        mem[40] = seeds[m];
        run(modes[m], cnts[c], 16'h0028, 32'h0);
        chk_w("check code", cnts[c] < 0 ? seeds[m]
              : calc(modes[m], seeds[m], 0, cnts[c]),
              mem[40]);
        chk_b("check error", cnts[c] < 0, err);
      end
    // reset in mid-run: unit must drop the run and come back idle
    @(posedge clk_sys);
    cmd_op         <= op_crc16;
    cmd_word_count <= 16'sh0008;
    cmd_valid      <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n             <= 1'b1;
    cmd_start_element <= 16'h0010;
    @(negedge clk_sys);
    chk_b("ready after mid reset", 1'b1, cmd_ready);
    chk_b("done after mid reset", 1'b0, op_done);
    chk_b("read after mid reset", 1'b0, mem_rd_req);
    mem[40] = 16'hFFFF;
    run(op_crc16, 16'sh0003, 16'h0028, 32'h0);
    chk_w("offset code", calc(op_crc16, 16'hFFFF, 16, 3), mem[40]);
    b0 = n_acc;
    run(op_zone_bit_set, 16'sh0003, 16'h000A, 32'h0);
    chk_w("zone set bits", 16'h1C00, bits[15:0]);
    run(op_zone_bit_reset, 16'sh0002, 16'h000B, 32'h0);
    chk_w("zone reset bits", 16'h0400, bits[15:0]);
    chk_w("value clears", 16'h0002, 16'(n_acc - b0));
    run(op_zone_bit_set, 16'shFFFE, 16'h0000, 32'h0);
    chk_w("empty zone bits", 16'h0400, bits[15:0]);
    chk_b("empty zone error", 1'b0, err);
    report_and_stop();
  end
endmodule // testbench
